/* pkg/pewc_pkg.sv */
// Constants and types for the parallel memory write controller
package pewc_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_LSB = 7;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  // Strobe low and high widths, ns
  localparam int STROBE_LOW_NS = 100;
  localparam int STROBE_HIGH_NS = 100;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Byte load window maximum, us; host waits this long to close a page
  localparam int LOAD_WINDOW_US = 100;
  localparam int LOAD_WINDOW_CYC = LOAD_WINDOW_US * 1000 / CLK_PERIOD_NS;
  // Read access and output float, ns
  localparam int READ_ACCESS_NS = 150;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_NS = 50;
  localparam int FLOAT_CYC = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Program cycle time, ms, and power-up write inhibit, ms
  localparam int PROGRAM_CYCLE_MS = 5;
  localparam int PROGRAM_CYCLE_CYC = PROGRAM_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POWERUP_INHIBIT_MS = 10;
  localparam int POWERUP_INHIBIT_CYC = POWERUP_INHIBIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
  localparam int LOCK_ENABLE_LEN = 3;
  localparam int LOCK_DISABLE_LEN = 6;
  localparam int CMD_MAX = 6;
  localparam logic [2:0] CMD_IDX_ZERO = 3'h0;
  localparam logic [7:0] IDX_ZERO = 8'h00;
  typedef enum logic [6:0] {
    PEWC_IDLE = 7'b000_0001,
    PEWC_SETUP = 7'b000_0010,
    PEWC_LOW = 7'b000_0100,
    PEWC_HIGH = 7'b000_1000,
    PEWC_CLOSE = 7'b001_0000,
    PEWC_POLL = 7'b010_0000,
    PEWC_READ = 7'b100_0000
  } pewc_state_t;
endpackage : pewc_pkg

/* logic/pewc_sync.sv */
// Two flip-flop synchroniser for the data pins coming back from the memory
`timescale 1ns/1ps
module pewc_sync #(
  parameter int W = 8
) (
  core_clk,
  rst,
  clk_en,
  din,
  dout
);
  input wire logic core_clk;
  input wire logic rst;
  input wire logic clk_en;
  input wire logic [W-1:0] din;
  output logic [W-1:0] dout;
  logic [W-1:0] meta_reg;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_reg <= '0;
      dout <= '0;
    end else if (clk_en) begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : pewc_sync

/* logic/pewc_ctrl.sv */
// Host controller driving a parallel electrically erasable memory over its pins
// Function
// - Low seven address bits pick the byte, any load order.
// - Loads are spaced inside the byte load window, never beyond it.
// - After the last load, strobe stays high a full byte load window.
// - Lock enable is three command writes with page load timing.
// - When locked, every data write is preceded by the three-command prefix.
// - Data loads follow the prefix within the byte load window.
// - Six command writes disable the lock.
`timescale 1ns/1ps
module pewc_ctrl #(
  parameter logic [16:0] CMD_A0 = 17'h0_5555,
  parameter logic [16:0] CMD_A1 = 17'h0_2AAA,
  parameter logic [7:0] CMD_D0 = 8'hAA,
  parameter logic [7:0] CMD_D1 = 8'h55,
  parameter logic [7:0] CMD_ENABLE = 8'hA0,
  parameter logic [7:0] CMD_DIS_A = 8'h80,
  parameter logic [7:0] CMD_DIS_B = 8'h20,
  parameter int LOAD_WINDOW_CYC = pewc_pkg::LOAD_WINDOW_CYC,
  parameter int PROGRAM_CYCLE_CYC = pewc_pkg::PROGRAM_CYCLE_CYC,
  parameter int POWERUP_INHIBIT_CYC = pewc_pkg::POWERUP_INHIBIT_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic supply_ok,
  input wire logic lock_mode,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_last,
  input wire logic [1:0] req_cmd,
  input wire logic [16:0] req_addr,
  input wire logic [7:0] req_data,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done_valid,
  output logic done_timeout,
  output logic mem_addr,
  output logic [16:0] mem_a,
  output logic chip_select_low,
  output logic output_drive_enable_low,
  output logic write_strobe_low,
  input wire logic [7:0] mem_dq_in,
  output logic [7:0] mem_dq_out,
  output logic mem_dq_oe
);
  localparam logic [1:0] CMD_DATA = 2'h0;
  localparam logic [1:0] CMD_LOCK_ON = 2'h1;
  localparam logic [1:0] CMD_LOCK_OFF = 2'h2;
  localparam logic [23:0] LOW_CYC = 24'(pewc_pkg::STROBE_LOW_CYC);
  localparam logic [23:0] HIGH_CYC = 24'(pewc_pkg::STROBE_HIGH_CYC);
  localparam logic [23:0] RD_CYC = 24'(pewc_pkg::READ_ACCESS_CYC + 2);
  localparam logic [23:0] FLT_CYC = 24'(pewc_pkg::FLOAT_CYC);
  localparam logic [23:0] WIN_CYC = 24'(LOAD_WINDOW_CYC);
  localparam logic [23:0] PROG_CYC = 24'(PROGRAM_CYCLE_CYC);
  localparam logic [23:0] INH_CYC = 24'(POWERUP_INHIBIT_CYC);

  pewc_pkg::pewc_state_t state_reg;
  logic [23:0] cnt_reg;
  logic [23:0] prog_reg;
  logic [23:0] inh_reg;
  logic [2:0] cmd_idx_reg;
  logic [2:0] cmd_len_reg;
  logic [1:0] kind_reg;
  logic last_reg;
  logic [16:0] addr_reg;
  logic [7:0] data_reg;
  logic [7:0] prev_reg;
  logic prev_valid_reg;
  logic [7:0] dq_sync;

  // Fixed command prefix step lookup, shared by address and data paths
  function automatic logic [24:0] cmd_step(input logic [2:0] idx, input logic off);
    case (idx)
      3'h0: cmd_step = {CMD_A0, CMD_D0};
      3'h1: cmd_step = {CMD_A1, CMD_D1};
      3'h2: cmd_step = {CMD_A0, off ? CMD_DIS_A : CMD_ENABLE};
      3'h3: cmd_step = {CMD_A0, CMD_D0};
      3'h4: cmd_step = {CMD_A1, CMD_D1};
      3'h5: cmd_step = {CMD_A0, CMD_DIS_B};
      default: cmd_step = {CMD_A0, CMD_D0};
    endcase
  endfunction : cmd_step

  pewc_sync #(.W(pewc_pkg::DATA_W)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .din(mem_dq_in),
    .dout(dq_sync)
  );

  logic writes_allowed;
  assign writes_allowed = supply_ok && (inh_reg == 24'h00_0000);
  assign req_ready = clk_en && (state_reg == pewc_pkg::PEWC_IDLE) &&
    (!req_write || writes_allowed);
  assign mem_addr = 1'b0;
  assign chip_select_low = (state_reg == pewc_pkg::PEWC_IDLE) ||
    (state_reg == pewc_pkg::PEWC_CLOSE);
  assign write_strobe_low = !(state_reg == pewc_pkg::PEWC_LOW);
  // Enable lifts for one cycle between polls, so each poll is a fresh read for the toggle bit
  assign output_drive_enable_low = !(state_reg == pewc_pkg::PEWC_READ ||
    (state_reg == pewc_pkg::PEWC_POLL && cnt_reg != 24'h00_0000));
  assign mem_dq_oe = (state_reg == pewc_pkg::PEWC_SETUP) ||
    (state_reg == pewc_pkg::PEWC_LOW) || (state_reg == pewc_pkg::PEWC_HIGH);

  // Power-up write inhibit countdown
  always_ff @(posedge core_clk) begin
    if (rst) begin
      inh_reg <= 24'hFF_FFFF;
    end else if (clk_en) begin
      if (!supply_ok) begin
        inh_reg <= INH_CYC;
      end else if (inh_reg > INH_CYC) begin
        inh_reg <= INH_CYC;
      end else if (inh_reg != 24'h00_0000) begin
        inh_reg <= inh_reg - 24'h00_0001;
      end
    end
  end

  // Sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= pewc_pkg::PEWC_IDLE;
      cnt_reg <= 24'h00_0000;
      prog_reg <= 24'h00_0000;
      cmd_idx_reg <= pewc_pkg::CMD_IDX_ZERO;
      cmd_len_reg <= pewc_pkg::CMD_IDX_ZERO;
      kind_reg <= CMD_DATA;
      last_reg <= 1'b0;
      addr_reg <= 17'h0_0000;
      data_reg <= 8'h00;
      mem_a <= 17'h0_0000;
      mem_dq_out <= 8'h00;
      prev_reg <= 8'h00;
      prev_valid_reg <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      done_valid <= 1'b0;
      done_timeout <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= 1'b0;
      done_valid <= 1'b0;
      case (state_reg)
        pewc_pkg::PEWC_IDLE: begin
          if (req_valid && req_ready) begin
            addr_reg <= req_addr;
            data_reg <= req_data;
            kind_reg <= req_cmd;
            last_reg <= req_last;
            cnt_reg <= 24'h00_0000;
            if (!req_write) begin
              mem_a <= req_addr;
              state_reg <= pewc_pkg::PEWC_READ;
            end else begin
              // Prefix length: three when locked or enabling, six to disable
              if (req_cmd == CMD_LOCK_OFF) begin
                cmd_len_reg <= 3'(pewc_pkg::LOCK_DISABLE_LEN);
              end else if (req_cmd == CMD_LOCK_ON || lock_mode) begin
                cmd_len_reg <= 3'(pewc_pkg::LOCK_ENABLE_LEN);
              end else begin
                cmd_len_reg <= pewc_pkg::CMD_IDX_ZERO;
              end
              cmd_idx_reg <= pewc_pkg::CMD_IDX_ZERO;
              state_reg <= pewc_pkg::PEWC_SETUP;
              {mem_a, mem_dq_out} <= (req_cmd != CMD_DATA || lock_mode) ?
                cmd_step(pewc_pkg::CMD_IDX_ZERO, req_cmd == CMD_LOCK_OFF) :
                {req_addr, req_data};
            end
          end
        end
        pewc_pkg::PEWC_SETUP: begin
          state_reg <= pewc_pkg::PEWC_LOW;
        end
        pewc_pkg::PEWC_LOW: begin
          cnt_reg <= cnt_reg + 24'h00_0001;
          if (cnt_reg + 24'h00_0001 >= LOW_CYC) begin
            cnt_reg <= 24'h00_0000;
            state_reg <= pewc_pkg::PEWC_HIGH;
          end
        end
        pewc_pkg::PEWC_HIGH: begin
          cnt_reg <= cnt_reg + 24'h00_0001;
          if (cnt_reg + 24'h00_0001 >= HIGH_CYC) begin
            cnt_reg <= 24'h00_0000;
            if (cmd_idx_reg + 3'h1 < cmd_len_reg) begin
              cmd_idx_reg <= cmd_idx_reg + 3'h1;
              {mem_a, mem_dq_out} <= cmd_step(cmd_idx_reg + 3'h1,
                kind_reg == CMD_LOCK_OFF);
              state_reg <= pewc_pkg::PEWC_SETUP;
            end else if (cmd_len_reg != pewc_pkg::CMD_IDX_ZERO && kind_reg == CMD_DATA) begin
              cmd_len_reg <= pewc_pkg::CMD_IDX_ZERO;
              {mem_a, mem_dq_out} <= {addr_reg, data_reg};
              state_reg <= pewc_pkg::PEWC_SETUP;
            end else if (!last_reg && kind_reg == CMD_DATA) begin
              // Page continues; next byte must arrive inside the window
              state_reg <= pewc_pkg::PEWC_CLOSE;
            end else begin
              state_reg <= pewc_pkg::PEWC_CLOSE;
            end
          end
        end
        pewc_pkg::PEWC_CLOSE: begin
          cnt_reg <= cnt_reg + 24'h00_0001;
          if (!last_reg && kind_reg == CMD_DATA && req_valid && req_write &&
              req_addr[16:7] == addr_reg[16:7]) begin
            addr_reg <= req_addr;
            data_reg <= req_data;
            last_reg <= req_last;
            mem_a <= req_addr;
            mem_dq_out <= req_data;
            cnt_reg <= 24'h00_0000;
            state_reg <= pewc_pkg::PEWC_SETUP;
          end else if (cnt_reg + 24'h00_0001 >= WIN_CYC) begin
            // Strobe held high a full window so programming starts
            cnt_reg <= 24'h00_0000;
            prog_reg <= 24'h00_0000;
            prev_valid_reg <= 1'b0;
            mem_a <= addr_reg;
            state_reg <= pewc_pkg::PEWC_POLL;
          end
        end
        pewc_pkg::PEWC_POLL: begin
          cnt_reg <= cnt_reg + 24'h00_0001;
          prog_reg <= prog_reg + 24'h00_0001;
          if (cnt_reg + 24'h00_0001 >= RD_CYC) begin
            cnt_reg <= 24'h00_0000;
            prev_reg <= dq_sync;
            prev_valid_reg <= 1'b1;
            // Done at the first poll for a command write; a data write is done when bit 7 matches the written data and bit 6 stopped toggling
            if (kind_reg != CMD_DATA ||
                (dq_sync[pewc_pkg::POLL_BIT] == data_reg[pewc_pkg::POLL_BIT] &&
                 prev_valid_reg &&
                 dq_sync[pewc_pkg::TOGGLE_BIT] == prev_reg[pewc_pkg::TOGGLE_BIT])) begin
              done_valid <= 1'b1;
              done_timeout <= 1'b0;
              state_reg <= pewc_pkg::PEWC_IDLE;
            end
          end
          if (prog_reg >= PROG_CYC) begin
            done_valid <= 1'b1;
            done_timeout <= 1'b1;
            state_reg <= pewc_pkg::PEWC_IDLE;
          end
        end
        pewc_pkg::PEWC_READ: begin
          cnt_reg <= cnt_reg + 24'h00_0001;
          if (cnt_reg + 24'h00_0001 >= RD_CYC + FLT_CYC) begin
            rd_data <= dq_sync;
            rd_valid <= 1'b1;
            state_reg <= pewc_pkg::PEWC_IDLE;
          end
        end
        default: begin
          state_reg <= pewc_pkg::PEWC_IDLE;
        end
      endcase
    end
  end
endmodule : pewc_ctrl

/* bench/pewc_ctrl_sva.sv */
// Pin and handshake assertions for the memory write controller
`timescale 1ns/1ps
module pewc_ctrl_sva #(
  parameter int POWERUP_INHIBIT_CYC = 50
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic supply_ok,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic rd_valid,
  input wire logic done_valid,
  input wire logic chip_select_low,
  input wire logic output_drive_enable_low,
  input wire logic write_strobe_low,
  input wire logic [16:0] mem_a,
  input wire logic [7:0] mem_dq_out,
  input wire logic mem_dq_oe
);
  // Window plus program bound plus polling, with margin for slow reads
  localparam int MAX_WAIT = 600;
  int up_reg;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk) begin
    if (rst || !supply_ok) begin
      up_reg <= 0;
    end else if (clk_en && up_reg < POWERUP_INHIBIT_CYC) begin
      up_reg <= up_reg + 1;
    end
  end
  rd_ctrl_a: assert property (
    !output_drive_enable_low |-> !chip_select_low && write_strobe_low && !mem_dq_oe)
    else $error("read with bad control pins");
  wr_ctrl_a: assert property (
    !write_strobe_low |-> output_drive_enable_low && !chip_select_low && mem_dq_oe)
    else $error("write strobe with bad control pins");
  strobe_width_a: assert property (
    $fell(write_strobe_low) |-> !write_strobe_low [*5])
    else $error("write strobe pulse too short");
  wr_hold_a: assert property (
    !write_strobe_low && !$past(write_strobe_low) |-> $stable(mem_a) && $stable(mem_dq_out))
    else $error("address or data moved under strobe");
  supply_block_a: assert property (
    !supply_ok && req_write |-> !req_ready)
    else $error("write accepted at low supply");
  powerup_block_a: assert property (
    up_reg < POWERUP_INHIBIT_CYC - 2 && req_write |-> !req_ready)
    else $error("write accepted during power-up delay");
  done_pulse_a: assert property (
    done_valid && clk_en |=> !done_valid)
    else $error("done longer than one cycle");
  freeze_hold_a: assert property (
    !clk_en |=> $stable(mem_a) && $stable(mem_dq_out) && $stable(write_strobe_low) &&
      $stable(output_drive_enable_low) && $stable(done_valid) && $stable(rd_valid))
    else $error("pins moved while clock enable low");
  done_bound_a: assert property (
    $rose(write_strobe_low) |-> ##[1:MAX_WAIT] ($fell(write_strobe_low) || done_valid))
    else $error("write never finished");
  cover property ($rose(done_valid));
  cover property (rd_valid);
  cover property ($fell(write_strobe_low) ##[1:40] $fell(write_strobe_low));
endmodule : pewc_ctrl_sva

bind pewc_ctrl pewc_ctrl_sva #(.POWERUP_INHIBIT_CYC(POWERUP_INHIBIT_CYC)) chk_u (
  .core_clk, .rst, .clk_en, .supply_ok, .req_ready, .req_write, .rd_valid, .done_valid,
  .chip_select_low, .output_drive_enable_low, .write_strobe_low, .mem_a, .mem_dq_out,
  .mem_dq_oe);

/* bench/pewc_mem_model.sv */
// Behavioural model of the parallel memory on the far side
`timescale 1ns/1ps
module pewc_mem_model #(
  parameter int BLC = 18,
  parameter int BUSY = 60
) (
  input wire logic clk,
  input wire logic cs_low,
  input wire logic oe_low,
  input wire logic we_low,
  input wire logic [16:0] a,
  input wire logic [7:0] host_dq,
  input wire logic host_oe,
  output logic [7:0] bus_q
);
  logic [7:0] mem [logic [16:0]];
  logic [16:0] la [$];
  logic [7:0] ld [$];
  logic [16:0] lat_a = 17'h0_0000;
  logic [7:0] last_q = 8'h00;
  logic [7:0] held = 8'h00;
  logic [7:0] q;
  logic we_q = 1'b1;
  logic rd_q = 1'b0;
  logic tog = 1'b0;
  logic locked = 1'b0;
  int blc = 0;
  int busy = 0;
  wire rd = !cs_low && !oe_low && we_low;
  function automatic bit hit(int i, logic [16:0] x, logic [7:0] d);
    return i < la.size() && la[i] === x && ld[i] === d;
  endfunction : hit
  function automatic bit pre(int i, logic [7:0] d);
    return hit(i, 17'h0_5555, 8'haa) && hit(i + 1, 17'h0_2aaa, 8'h55) && hit(i + 2, 17'h0_5555, d);
  endfunction : pre
  task automatic commit();
    int k;
    k = locked ? la.size() : 0;
    if (pre(0, 8'h80) && pre(3, 8'h20)) begin
      locked = 1'b0;
      k = 6;
    end else if (pre(0, 8'ha0)) begin
      locked = 1'b1;
      k = 3;
    end
    for (int i = k; i < la.size(); i++) begin
      mem[{lat_a[16:7], la[i][6:0]}] = ld[i];
      last_q = ld[i];
    end
    // A bare command prefix writes no byte, so no program cycle follows
    if (k < la.size()) busy = BUSY;
    la.delete();
    ld.delete();
  endtask : commit
  // Sampled on the clock, so sub-cycle glitches never load a byte
  always @(posedge clk) begin
    if (we_q && !we_low && !cs_low && oe_low && busy == 0) lat_a = a;
    if (!we_q && we_low && !cs_low && oe_low && busy == 0) begin
      la.push_back(lat_a);
      ld.push_back(host_dq);
      blc = BLC;
    end else if (blc > 0 && we_low) begin
      blc--;
      if (blc == 0) commit();
    end
    if (busy > 0) busy--;
    if (rd && !rd_q && busy > 0) tog = !tog;
    if (rd) held = q;
    we_q = we_low;
    rd_q = rd;
  end
  // Released bus shows the inverse of the last value, never a lucky match
  always @* begin
    q = busy > 0 ? {~last_q[7], tog, ~last_q[5:0]} : (mem.exists(a) ? mem[a] : 8'hff);
    bus_q = host_oe ? host_dq : (rd ? q : ~held);
  end
endmodule : pewc_mem_model

/* bench/testbench.sv */
// Self-checking bench for the parallel memory write controller
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic supply_ok = 1'b1;
  logic lock_mode = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_last = 1'b0;
  logic [1:0] req_cmd = 2'h0;
  logic [16:0] req_addr = 17'h0_0000;
  logic [7:0] req_data = 8'h00;
  logic req_ready, rd_valid, done_valid, done_timeout, mem_dq_oe, mem_addr;
  logic [31:0] rng_en = 32'h0000_3b44;
  logic jit = 1'b0;
  logic chip_select_low, output_drive_enable_low, write_strobe_low;
  logic [16:0] mem_a;
  logic [7:0] rd_data, mem_dq_out, mem_dq_in;
  logic [8:0] exp_q [$];
  logic [8:0] e;
  logic [7:0] pd [4];
  logic [16:0] offs [4] = '{17'h0_0005, 17'h0_0001, 17'h0_007f, 17'h0_0000};
  logic [31:0] rng = 32'h0000_3b44;
  int miscompares = 0;
  int checks_done = 0;
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  pewc_ctrl #(.LOAD_WINDOW_CYC(20), .PROGRAM_CYCLE_CYC(200), .POWERUP_INHIBIT_CYC(50)) dut_u (
    .core_clk, .rst, .clk_en, .supply_ok, .lock_mode, .req_valid, .req_ready, .req_write,
    .req_last, .req_cmd, .req_addr, .req_data, .rd_valid, .rd_data, .done_valid,
    .done_timeout, .mem_addr(mem_addr), .mem_a, .chip_select_low, .output_drive_enable_low,
    .write_strobe_low, .mem_dq_in, .mem_dq_out, .mem_dq_oe);
  pewc_mem_model mem_u (.clk(core_clk), .cs_low(chip_select_low),
    .oe_low(output_drive_enable_low), .we_low(write_strobe_low), .a(mem_a),
    .host_dq(mem_dq_out), .host_oe(mem_dq_oe), .bus_q(mem_dq_in));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // Random enable gaps stretch every phase in time but not in counted cycles
  always @(posedge core_clk) begin
    rng_en <= xs(rng_en);
    clk_en <= !jit || rng_en[3:0] != 4'h0;
  end
  task automatic cmp_byte(input string n, input logic [7:0] x, input logic [7:0] g);
    checks_done++;
    if (x !== g) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : cmp_byte
  task automatic cmp_bit(input string n, input logic x, input logic g);
    checks_done++;
    if (x !== g) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", n, x, g);
    end
  endtask : cmp_bit
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  // A write counts as taken once its strobe falls; page bytes need no ready
  task automatic send(input logic w, input logic l, input logic [1:0] c,
      input logic [16:0] ad, input logic [7:0] d);
    int n;
    logic p;
    logic hit;
    req_valid <= 1'b1;
    req_write <= w;
    req_last <= l;
    req_cmd <= c;
    req_addr <= ad;
    req_data <= d;
    n = 0;
    p = write_strobe_low;
    do begin
      @(posedge core_clk);
      n++;
      hit = w ? (p === 1'b1 && write_strobe_low === 1'b0) : (req_ready === 1'b1);
      p = write_strobe_low;
    end while (!hit && n < 3000);
    if (n >= 3000) cmp_bit("handshake", 1'b1, 1'b0);
    if (l) req_valid <= 1'b0;
  endtask : send
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 3000) cmp_bit("drain", 1'b1, 1'b0);
    @(posedge core_clk);
  endtask : drain
  task automatic wr(input logic [16:0] ad, input logic [7:0] d);
    exp_q.push_back(9'h100);
    send(1'b1, 1'b1, 2'h0, ad, d);
    drain();
  endtask : wr
  task automatic rd(input logic [16:0] ad, input logic [7:0] d);
    exp_q.push_back({1'b0, d});
    send(1'b0, 1'b1, 2'h0, ad, 8'h00);
    drain();
  endtask : rd
  task automatic refuse(input string n);
    req_write <= 1'b1;
    req_valid <= 1'b1;
    repeat (10) begin
      @(posedge core_clk);
      cmp_bit(n, 1'b0, req_ready);
    end
    req_valid <= 1'b0;
  endtask : refuse
  always @(posedge core_clk) begin
    if (clk_en === 1'b1 && (rd_valid === 1'b1 || done_valid === 1'b1)) begin
      if (exp_q.size() == 0) begin
        cmp_bit("spare result", 1'b0, 1'b1);
      end else begin
        e = exp_q.pop_front();
        cmp_bit("done_valid", e[8], done_valid);
        if (!e[8]) cmp_byte("rd_data", e[7:0], rd_data);
        else if (!e[7]) cmp_bit("done_timeout", 1'b0, done_timeout);
      end
    end
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    finish_test();
  end
  initial begin
    logic [16:0] a;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    refuse("ready_inhibit");
    $display("test power-up inhibit done");
    repeat (60) @(posedge core_clk);
    rd(17'h1_ffff, 8'hff);
    jit <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rng = xs(rng);
      wr(rng[16:0], rng[31:24]);
      rd(rng[16:0], rng[31:24]);
    end
    jit <= 1'b0;
    $display("test byte write done");
    rng = xs(rng);
    a = {rng[16:7], 7'h00};
    exp_q.push_back(9'h100);
    for (int i = 0; i < 4; i++) begin
      pd[i] = rng[8 * i +: 8];
      send(1'b1, i == 3, 2'h0, a | offs[i], pd[i]);
    end
    drain();
    for (int i = 0; i < 4; i++) rd(a | offs[i], pd[i]);
    rd(a | 17'h0_0002, 8'hff);
    $display("test page write done");
    supply_ok <= 1'b0;
    repeat (2) @(posedge core_clk);
    refuse("ready_low_supply");
    supply_ok <= 1'b1;
    repeat (60) @(posedge core_clk);
    wr(a, 8'h3c);
    rd(a, 8'h3c);
    $display("test low supply done");
    exp_q.push_back(9'h180);
    send(1'b1, 1'b1, 2'h1, 17'h0_0000, 8'h00);
    drain();
    lock_mode <= 1'b1;
    wr(a, 8'hc3);
    rd(a, 8'hc3);
    exp_q.push_back(9'h180);
    send(1'b1, 1'b1, 2'h2, 17'h0_0000, 8'h00);
    drain();
    lock_mode <= 1'b0;
    wr(a, 8'h5a);
    rd(a, 8'h5a);
    cmp_bit("mem_addr", 1'b0, mem_addr);
    $display("test write lock done");
    finish_test();
  end
endmodule : testbench
